// *** hw/clbo_pkg.sv ***
// constants, types and helpers of the logic / bit / clock execution unit
// assumes 24-bit working registers and a 32-bit ahb-lite register bus
package clbo_pkg;

   localparam int          CLBO_DW        = 24;

   // register byte offsets
   localparam logic [7:0]  CLBO_OFS_CMD   = 8'h00;
   localparam logic [7:0]  CLBO_OFS_IMM   = 8'h04;
   localparam logic [7:0]  CLBO_OFS_STAT  = 8'h08;
   localparam logic [7:0]  CLBO_OFS_X     = 8'h0c;
   localparam logic [7:0]  CLBO_OFS_Y     = 8'h10;
   localparam logic [7:0]  CLBO_OFS_Z     = 8'h14;
   localparam logic [7:0]  CLBO_OFS_PTR   = 8'h18;
   localparam logic [7:0]  CLBO_OFS_RAMD  = 8'h1c;

   // command word field positions
   localparam int          CLBO_CMD_OP    = 0;
   localparam int          CLBO_CMD_DST   = 4;
   localparam int          CLBO_CMD_SRC   = 6;
   localparam int          CLBO_CMD_CONST = 8;
   localparam int          CLBO_CMD_POS   = 16;

   // status word field positions
   localparam int          CLBO_ST_BUSY   = 0;
   localparam int          CLBO_ST_Z      = 1;
   localparam int          CLBO_ST_S      = 2;
   localparam int          CLBO_ST_O      = 3;
   localparam int          CLBO_ST_C      = 4;
   localparam int          CLBO_ST_SSEL   = 8;
   localparam int          CLBO_ST_SON    = 9;
   localparam int          CLBO_ST_BYTES  = 12;

   // operation codes
   localparam logic [2:0]  CLBO_OP_AND    = 3'h0;
   localparam logic [2:0]  CLBO_OP_BITCLR = 3'h1;
   localparam logic [2:0]  CLBO_OP_BITINV = 3'h2;
   localparam logic [2:0]  CLBO_OP_BITSET = 3'h3;
   localparam logic [2:0]  CLBO_OP_CLEAR  = 3'h4;
   localparam logic [2:0]  CLBO_OP_SLOW   = 3'h5;
   localparam logic [2:0]  CLBO_OP_CLRCO  = 3'h6;

   // cycle counts and byte lengths per operation
   localparam logic [2:0]  CLBO_CYC_ANDA  = 3'h3;
   localparam logic [2:0]  CLBO_CYC_ANDK  = 3'h6;
   localparam logic [2:0]  CLBO_CYC_BIT   = 3'h2;
   localparam logic [2:0]  CLBO_CYC_CLEAR = 3'h1;
   localparam logic [2:0]  CLBO_CYC_SLOW  = 3'h3;
   localparam logic [2:0]  CLBO_CYC_CLRCO = 3'h1;
   localparam logic [3:0]  CLBO_LEN_ANDA  = 4'h2;
   localparam logic [3:0]  CLBO_LEN_ANDK  = 4'h5;
   localparam logic [3:0]  CLBO_LEN_BIT   = 4'h2;
   localparam logic [3:0]  CLBO_LEN_CLEAR = 4'h1;
   localparam logic [3:0]  CLBO_LEN_SLOW  = 4'h2;
   localparam logic [3:0]  CLBO_LEN_CLRCO = 4'h1;

   // values after reset
   localparam logic [23:0] CLBO_ACC_RST   = 24'h000000;
   localparam logic [3:0]  CLBO_FLAG_RST  = 4'h0;

   // operand selector: three registers and the pointer-addressed word
   typedef enum logic [1:0] {CLBO_SEL_X, CLBO_SEL_Y, CLBO_SEL_Z,
                             CLBO_SEL_R} clbo_sel_t;

   // cycles an operation occupies
   function automatic logic [2:0] clbo_op_cycles(input logic [2:0] op,
                                                 input logic       k);
      case (op)
         CLBO_OP_AND:   return k ? CLBO_CYC_ANDK : CLBO_CYC_ANDA;
         CLBO_OP_CLEAR: return CLBO_CYC_CLEAR;
         CLBO_OP_SLOW:  return CLBO_CYC_SLOW;
         CLBO_OP_CLRCO: return CLBO_CYC_CLRCO;
         default:       return CLBO_CYC_BIT;
      endcase
   endfunction

   // bytes an operation occupies in program memory
   function automatic logic [3:0] clbo_op_bytes(input logic [2:0] op,
                                                input logic       k);
      case (op)
         CLBO_OP_AND:   return k ? CLBO_LEN_ANDK : CLBO_LEN_ANDA;
         CLBO_OP_CLEAR: return CLBO_LEN_CLEAR;
         CLBO_OP_SLOW:  return CLBO_LEN_SLOW;
         CLBO_OP_CLRCO: return CLBO_LEN_CLRCO;
         default:       return CLBO_LEN_BIT;
      endcase
   endfunction

   // one-hot mask of a bit position; positions above 23 give no bit
   function automatic logic [23:0] clbo_bit_mask(input logic [4:0] pos);
      logic [23:0] m;
      m = 24'h000000;
      if (pos < 5'd24)
         m[pos] = 1'b1;
      return m;
   endfunction

   // pick one of the three working registers or the pointer-addressed ram word
   function automatic logic [23:0] clbo_pick(input clbo_sel_t   sel,
                                             input logic [23:0] x,
                                             input logic [23:0] y,
                                             input logic [23:0] z,
                                             input logic [23:0] r);
      case (sel)
         CLBO_SEL_X: return x;
         CLBO_SEL_Y: return y;
         CLBO_SEL_Z: return z;
         default:    return r;
      endcase
   endfunction

endpackage

// *** hw/clbo_ram_if.sv ***
// signals between the execution unit and its working ram
// assumes one clock shared by both ends
`timescale 1ns/1ns
`default_nettype none
interface clbo_ram_if #(parameter int AW = 6, parameter int DW = 24);
   logic [AW-1:0] addr;
   logic          we;
   logic [DW-1:0] wdata;
   logic [DW-1:0] rdata;
   modport ctrl (output addr, output we, output wdata, input rdata);
   modport mem  (input addr, input we, input wdata, output rdata);
endinterface
`default_nettype wire

// *** hw/clbo_ram.sv ***
// working ram of 24-bit words, one write and one registered read port
// assumes the controller holds the address steady while it needs the word
`timescale 1ns/1ns
`default_nettype none
module clbo_ram
   import clbo_pkg::*;
#(
   parameter int AW = 6
)(
   // clock
   input  wire logic  hclk,
   // memory side
   clbo_ram_if.mem    ram
);
   logic [CLBO_DW-1:0] mem_q [2**AW];
   logic [CLBO_DW-1:0] rdata_r;

   ////////////////////////////////////////////////////////////////////////
   // write on we, read data registered; a write shows one edge later
   always_ff @(posedge hclk)
   begin
      if (ram.we)
         mem_q[ram.addr] <= ram.wdata;
      rdata_r <= mem_q[ram.addr];
   end

   assign ram.rdata = rdata_r;
endmodule
`default_nettype wire

// *** hw/clbo_exec.sv ***
// execution unit for and, bit clear/invert/set, clear, slow clock select
// and carry/overflow clear, with an ahb-lite register slave
// assumes a single-master ahb-lite bus on hclk; clock mux lies outside
// Contract
// RULE1 - and: destination gets destination and second operand; s,z updated
// RULE2 - and with register: 2 bytes, 3 cycles; with constant: 5 bytes, 6
// RULE3 - bit clear zeroes selected bit 0..23; s,z updated; 2 bytes 2 cycles
// RULE4 - bit invert xors one-hot mask into destination; s,z; 2 bytes 2 cycles
// RULE5 - bit set forces selected bit to one; s,z; 2 bytes 2 cycles
// RULE6 - clear writes zero to the register; s,z updated; 1 byte 1 cycle
// RULE7 - slow select 1 runs from 10 kHz; 0 turns slow clock off
// RULE8 - slow select: 2 bytes, 3 cycles, arithmetic flags untouched
// RULE9 - program must pass default clock between fast and slow selections
// RULE10 - carry/overflow clear zeroes c and o; 1 byte 1 cycle
// RULE11 - every register operand picks x, y, z or r
// RULE12 - r is the ram word at the pointer, used like a register
// RULE13 - flags follow the latest flag-affecting operation; 24-bit words
// RULE14 - z when result all zero, s copies bit 23, others hold
// RULE15 - clock change lands glitch-free after the operation completes
`timescale 1ns/1ns
`default_nettype none
module clbo_exec
   import clbo_pkg::*;
#(
   parameter int AW = 6
)(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // processor clock control
   output logic             slow_clk_sel,
   output logic             slow_osc_en,
   output logic             exec_busy
);
   typedef enum logic {CLBO_IDLE, CLBO_EXEC} clbo_state_t;

   clbo_ram_if #(.AW(AW), .DW(CLBO_DW)) ram ();

   clbo_state_t        state_r, state_nxt;
   logic [2:0]         cnt_r, cnt_nxt;
   logic [2:0]         op_r;
   clbo_sel_t          dst_r, src_r;
   logic               kconst_r;
   logic [4:0]         pos_r;
   logic [23:0]        imm_r;
   logic [23:0]        acc_x_r, acc_y_r, acc_z_r;
   logic [AW-1:0]      ptr_r;
   logic               flag_c_r, flag_o_r, flag_s_r, flag_z_r;
   logic               ssel_r, son_r;
   logic [3:0]         bytes_r;
   logic               wpend_r, rwait_r;
   logic [7:0]         wa_r, ra_r;
   logic [31:0]        hrdata_r;

   ////////////////////////////////////////////////////////////////////////
   // bus decode: address phase, write data phase, refusal while busy
   logic        ap_valid, ap_wr, ap_rd, idle, wr_ok;
   logic        wr_cmd, wr_imm, wr_stat, wr_x, wr_y, wr_z, wr_ptr, wr_ramd;
   logic [2:0]  cmd_op;
   logic        cmd_k;
   assign ap_valid = hsel && htrans[1] && hready;
   assign ap_wr    = ap_valid && hwrite;
   assign ap_rd    = ap_valid && !hwrite;
   assign idle     = (state_r == CLBO_IDLE);
   assign wr_ok    = wpend_r && idle;      // writes while busy are dropped
   assign wr_cmd   = wr_ok && (wa_r == CLBO_OFS_CMD);
   assign wr_imm   = wr_ok && (wa_r == CLBO_OFS_IMM);
   assign wr_stat  = wr_ok && (wa_r == CLBO_OFS_STAT);
   assign wr_x     = wr_ok && (wa_r == CLBO_OFS_X);
   assign wr_y     = wr_ok && (wa_r == CLBO_OFS_Y);
   assign wr_z     = wr_ok && (wa_r == CLBO_OFS_Z);
   assign wr_ptr   = wr_ok && (wa_r == CLBO_OFS_PTR);
   assign wr_ramd  = wr_ok && (wa_r == CLBO_OFS_RAMD);
   assign cmd_op   = hwdata[CLBO_CMD_OP +: 3];
   assign cmd_k    = hwdata[CLBO_CMD_CONST];

   // answers: writes in zero waits, reads with one wait, always okay
   assign hreadyout = !rwait_r;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_r;

   // bus phase tracking
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wpend_r <= 1'b0;
         rwait_r <= 1'b0;
         wa_r    <= 8'h00;
         ra_r    <= 8'h00;
      end
      else
      begin
         wpend_r <= ap_wr;
         rwait_r <= ap_rd;
         if (ap_valid)
         begin
            wa_r <= haddr[7:0];
            ra_r <= haddr[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // operand fetch and result
   logic        commit, start, acc_op, flag_op;
   logic [23:0] dst_val, src_val, mask, result;
   assign start   = wr_cmd;
   assign commit  = (state_r == CLBO_EXEC) && (cnt_r == 3'h0);
   assign mask    = clbo_bit_mask(pos_r);
   assign dst_val = clbo_pick(dst_r, acc_x_r, acc_y_r, acc_z_r,
                              ram.rdata);                        // RULE11
   assign src_val = kconst_r ? imm_r
                  : clbo_pick(src_r, acc_x_r, acc_y_r, acc_z_r,
                              ram.rdata);                        // RULE11
   assign acc_op  = (op_r <= CLBO_OP_CLEAR);
   assign flag_op = acc_op || (op_r == CLBO_OP_CLRCO);

   // result of the accumulator operations
   always_comb
   begin
      case (op_r)
         CLBO_OP_AND:    result = dst_val & src_val;             // RULE1
         CLBO_OP_BITCLR: result = dst_val & ~mask;               // RULE3
         CLBO_OP_BITINV: result = dst_val ^ mask;                // RULE4
         CLBO_OP_BITSET: result = dst_val | mask;                // RULE5
         CLBO_OP_CLEAR:  result = CLBO_ACC_RST;                  // RULE6
         default:        result = dst_val;
      endcase
   end

   // ram port: pointer word, written by a commit to r or by software
   assign ram.addr  = ptr_r;
   assign ram.we    = (commit && acc_op && dst_r == CLBO_SEL_R) || wr_ramd;
   assign ram.wdata = commit ? result : hwdata[23:0];            // RULE12

   clbo_ram #(.AW(AW)) u_ram (
      .hclk (hclk),
      .ram  (ram.mem)
   );

   ////////////////////////////////////////////////////////////////////////
   // sequencer: counts the cycles of the operation, commits on the last
   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      case (state_r)
         CLBO_IDLE:
            if (start)
            begin
               state_nxt = CLBO_EXEC;
               cnt_nxt   = clbo_op_cycles(cmd_op, cmd_k) - 3'h1; // RULE2
            end
         CLBO_EXEC:
            if (cnt_r == 3'h0)
               state_nxt = CLBO_IDLE;
            else
               cnt_nxt = cnt_r - 3'h1;
         default:
            state_nxt = CLBO_IDLE;
      endcase
   end

   // sequencer state and latched command
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_r  <= CLBO_IDLE;
         cnt_r    <= 3'h0;
         op_r     <= CLBO_OP_AND;
         dst_r    <= CLBO_SEL_X;
         src_r    <= CLBO_SEL_X;
         kconst_r <= 1'b0;
         pos_r    <= 5'h00;
         bytes_r  <= 4'h0;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         if (start)
         begin
            op_r     <= cmd_op;
            dst_r    <= clbo_sel_t'(hwdata[CLBO_CMD_DST +: 2]);
            src_r    <= clbo_sel_t'(hwdata[CLBO_CMD_SRC +: 2]);
            kconst_r <= cmd_k;
            pos_r    <= hwdata[CLBO_CMD_POS +: 5];
            bytes_r  <= clbo_op_bytes(cmd_op, cmd_k);            // RULE8
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // working registers, pointer and constant
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         acc_x_r <= CLBO_ACC_RST;
         acc_y_r <= CLBO_ACC_RST;
         acc_z_r <= CLBO_ACC_RST;
         imm_r   <= CLBO_ACC_RST;
         ptr_r   <= '0;
      end
      else
      begin
         if (wr_x || (commit && acc_op && dst_r == CLBO_SEL_X))
            acc_x_r <= commit ? result : hwdata[23:0];           // RULE11
         if (wr_y || (commit && acc_op && dst_r == CLBO_SEL_Y))
            acc_y_r <= commit ? result : hwdata[23:0];
         if (wr_z || (commit && acc_op && dst_r == CLBO_SEL_Z))
            acc_z_r <= commit ? result : hwdata[23:0];
         if (wr_imm)
            imm_r <= hwdata[23:0];
         if (wr_ptr)
            ptr_r <= hwdata[AW-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // flags: s,z from accumulator results, c,o cleared, rest hold
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         {flag_c_r, flag_o_r, flag_s_r, flag_z_r} <= CLBO_FLAG_RST;
      else if (commit && acc_op)
      begin
         flag_s_r <= result[23];                                 // RULE14
         flag_z_r <= (result == 24'h000000);                     // RULE13
      end
      else if (commit && flag_op)
      begin
         flag_c_r <= 1'b0;                                       // RULE10
         flag_o_r <= 1'b0;
      end
      else if (wr_stat)
      begin
         flag_c_r <= hwdata[CLBO_ST_C];
         flag_o_r <= hwdata[CLBO_ST_O];
         flag_s_r <= hwdata[CLBO_ST_S];
         flag_z_r <= hwdata[CLBO_ST_Z];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // processor clock selection, changed once at the end of the operation
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ssel_r <= 1'b0;
         son_r  <= 1'b0;
      end
      else if (commit && op_r == CLBO_OP_SLOW)                   // RULE15
      begin
         ssel_r <= pos_r[0];                                     // RULE7
         son_r  <= pos_r[0];
      end
   end

   assign slow_clk_sel = ssel_r;
   assign slow_osc_en  = son_r;
   assign exec_busy    = !idle;

   ////////////////////////////////////////////////////////////////////////
   // read mux, loaded in the wait cycle so ram data is settled
   logic [31:0] rd_mux, stat_word;
   always_comb
   begin
      stat_word                     = 32'h00000000;
      stat_word[CLBO_ST_BUSY]       = !idle;
      stat_word[CLBO_ST_Z]          = flag_z_r;
      stat_word[CLBO_ST_S]          = flag_s_r;
      stat_word[CLBO_ST_O]          = flag_o_r;
      stat_word[CLBO_ST_C]          = flag_c_r;
      stat_word[CLBO_ST_SSEL]       = ssel_r;
      stat_word[CLBO_ST_SON]        = son_r;
      stat_word[CLBO_ST_BYTES +: 4] = bytes_r;
      case (ra_r)
         CLBO_OFS_IMM:  rd_mux = {8'h00, imm_r};
         CLBO_OFS_STAT: rd_mux = stat_word;
         CLBO_OFS_X:    rd_mux = {8'h00, acc_x_r};
         CLBO_OFS_Y:    rd_mux = {8'h00, acc_y_r};
         CLBO_OFS_Z:    rd_mux = {8'h00, acc_z_r};
         CLBO_OFS_PTR:  rd_mux = {{(32-AW){1'b0}}, ptr_r};
         CLBO_OFS_RAMD: rd_mux = {8'h00, ram.rdata};
         default:       rd_mux = 32'h00000000;
      endcase
   end

   // read data register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata_r <= 32'h00000000;
      else if (rwait_r)
         hrdata_r <= rd_mux;
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chk_and_result: assert property (                             // RULE1
      commit && op_r == CLBO_OP_AND && dst_r == CLBO_SEL_X
      |=> acc_x_r == ($past(acc_x_r) & $past(src_val)))
      else $error("and result wrong");
   chk_and_reg_time: assert property (                           // RULE2
      start && cmd_op == CLBO_OP_AND && !cmd_k
      |=> exec_busy [*3] ##1 !exec_busy)
      else $error("and with register not 3 cycles");
   chk_and_const_time: assert property (                         // RULE2
      start && cmd_op == CLBO_OP_AND && cmd_k
      |=> exec_busy [*6] ##1 !exec_busy)
      else $error("and with constant not 6 cycles");
   chk_bitclr_value: assert property (                           // RULE3
      commit && op_r == CLBO_OP_BITCLR && dst_r == CLBO_SEL_Y
      |=> acc_y_r == ($past(acc_y_r) & ~clbo_bit_mask(pos_r)))
      else $error("bit clear wrong");
   chk_bitinv_value: assert property (                           // RULE4
      commit && op_r == CLBO_OP_BITINV && dst_r == CLBO_SEL_Z
      |=> acc_z_r == ($past(acc_z_r) ^ clbo_bit_mask(pos_r)))
      else $error("bit invert wrong");
   chk_bitset_value: assert property (                           // RULE5
      commit && op_r == CLBO_OP_BITSET && dst_r == CLBO_SEL_X
      |=> acc_x_r == ($past(acc_x_r) | clbo_bit_mask(pos_r)))
      else $error("bit set wrong");
   chk_clear_zero: assert property (                             // RULE6
      start && cmd_op == CLBO_OP_CLEAR
      && hwdata[CLBO_CMD_DST +: 2] == 2'h1
      |=> exec_busy ##1 (!exec_busy && acc_y_r == 24'h000000 && flag_z_r))
      else $error("clear wrong");
   chk_slow_select: assert property (                            // RULE7
      commit && op_r == CLBO_OP_SLOW
      |=> slow_clk_sel == $past(pos_r[0]) && slow_osc_en == $past(pos_r[0]))
      else $error("slow clock select wrong");
   chk_slow_flags: assert property (                             // RULE8
      start && cmd_op == CLBO_OP_SLOW
      |=> exec_busy [*3] ##1 (!exec_busy
          && {flag_c_r, flag_o_r, flag_s_r, flag_z_r}
             == $past({flag_c_r, flag_o_r, flag_s_r, flag_z_r}, 4)))
      else $error("slow select timing or flags wrong");
   chk_clrco_flags: assert property (                            // RULE10
      start && cmd_op == CLBO_OP_CLRCO
      |=> ##1 (!exec_busy && !flag_c_r && !flag_o_r
          && flag_s_r == $past(flag_s_r, 2)
          && flag_z_r == $past(flag_z_r, 2)))
      else $error("carry overflow clear wrong");
   chk_sz_follow: assert property (                              // RULE14
      commit && acc_op
      |=> flag_s_r == $past(result[23])
          && flag_z_r == ($past(result) == 24'h000000)
          && $stable({flag_c_r, flag_o_r}))
      else $error("sign or zero flag wrong");
   chk_clk_steady: assert property (                             // RULE15
      !(commit && op_r == CLBO_OP_SLOW) |=> $stable(slow_clk_sel))
      else $error("clock select moved outside commit");
endmodule
`default_nettype wire

// *** sim/cpu_logic_bit_clock_ops_tb.sv ***
// self-checking bench of the logic / bit / clock execution unit
// assumes clbo_pkg and the design files are compiled first
`timescale 1ns/1ns
`default_nettype none
module cpu_logic_bit_clock_ops_tb;
   import clbo_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic        slow_clk_sel, slow_osc_en, exec_busy, sclk;
   logic [23:0] acc [4];
   logic [23:0] imm;
   logic [3:0]  fl;
   logic [7:0]  bcnt = 8'h00;
   logic [7:0]  blen = 8'h00;
   int          err_total, checks_done;

   clbo_exec dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .slow_clk_sel(slow_clk_sel),
      .slow_osc_en(slow_osc_en), .exec_busy(exec_busy));

   ////////////////////////////////////////////////////////////////////////
   // expectations and bus tasks
   function automatic logic [7:0] cyc(input logic [2:0] o, input logic k);
      return (o == 0) ? (k ? 8'h06 : 8'h03) : (o == 4 || o == 6) ? 8'h01
           : (o == 5) ? 8'h03 : 8'h02;
   endfunction
   function automatic logic [3:0] len(input logic [2:0] o, input logic k);
      return (o == 0) ? (k ? 4'h5 : 4'h2) : (o == 4 || o == 6) ? 4'h1 : 4'h2;
   endfunction
   function automatic logic [23:0] res(input logic [2:0] o,
                                       input logic [23:0] a, b, m);
      case (o)
         3'h0: return a & b;
         3'h1: return a & ~m;
         3'h2: return a ^ m;
         3'h3: return a | m;
         3'h4: return 24'h000000;
         default: return a;
      endcase
   endfunction
   function automatic logic [7:0] ra(input int i);
      return (i == 3) ? CLBO_OFS_RAMD : CLBO_OFS_X + 8'(4 * i);
   endfunction

   task automatic test_done();
      if (err_total == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // bounded wait for hready high at a rising edge
   task automatic rdy();
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
      begin
         n++;
         if (n > 50)
         begin
            err_total++;
            test_done();
         end
         @(posedge hclk);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      htrans <= 2'b10;
      haddr  <= {24'h000000, a};
      hwrite <= w;
      rdy();
      htrans <= 2'b00;
      hwdata <= w ? d : 32'h00000000;
      rdy();
      rd = hrdata;
   endtask
   // poll status until the operation has finished
   task automatic idle();
      for (int n = 0; n < 20; n++)
      begin
         xfer(1'b0, CLBO_OFS_STAT, 32'h0);
         if (rd[0] === 1'b0)
            return;
      end
      err_total++;
      test_done();
   endtask
   task automatic op(input logic [2:0] o, input logic [1:0] d, s,
                     input logic k, input logic [4:0] p);
      logic [23:0] r;
      logic [23:0] m;
      m = 24'h000000;
      m[p] = 1'b1;
      r = res(o, acc[d], k ? imm : acc[s], m);
      xfer(1'b1, CLBO_OFS_CMD, {11'h0, p, 7'h0, k, s, d, 1'b0, o});
      if (o == 0 && k)
         xfer(1'b1, CLBO_OFS_X, {8'h00, ~acc[0]}); // dropped while busy
      idle();
      chk(32'(blen), 32'(cyc(o, k)));
      if (o < 5)
      begin
         acc[d] = r;
         fl[1:0] = {r[23], r == 24'h000000};
      end
      if (o == 6)
         fl[3:2] = 2'b00;
      if (o == 5)
         sclk = p[0];
      for (int i = 0; i < 4; i++)
      begin
         xfer(1'b0, ra(i), 32'h0);
         chk(rd, 32'(acc[i]));
      end
      xfer(1'b0, CLBO_OFS_STAT, 32'h0);
      chk(rd, {16'h0, len(o, k), 2'b00, sclk, sclk, 3'h0, fl, 1'b0});
      chk({29'h0, hresp, slow_osc_en, slow_clk_sel}, {30'h0, sclk, sclk});
   endtask

   ////////////////////////////////////////////////////////////////////////
   // clock and busy length monitor
   initial
   begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   always @(posedge hclk)
      if (exec_busy === 1'b1)
         bcnt <= bcnt + 8'h01;
      else if (bcnt != 8'h00)
      begin
         blen <= bcnt;
         bcnt <= 8'h00;
      end

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b1;
      htrans = 2'b00;
      haddr = 32'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      err_total = 0;
      checks_done = 0;
      sclk = 1'b0;
      fl = 4'h0;
      imm = 24'h000000;
      void'($urandom(34417));
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      xfer(1'b0, CLBO_OFS_STAT, 32'h0);
      chk(rd, 32'h0);
      xfer(1'b1, 8'h20, 32'hffffffff);
      xfer(1'b0, 8'h20, 32'h0);
      chk(rd, 32'h0);
      xfer(1'b1, CLBO_OFS_PTR, 32'h00000005);
      xfer(1'b0, CLBO_OFS_PTR, 32'h0);
      chk(rd, 32'h00000005);
      for (int i = 0; i < 4; i++)
      begin
         acc[i] = 24'($urandom);
         xfer(1'b1, ra(i), {8'h00, acc[i]});
      end
      // corner cases, then random operations with random preset flags
      op(3'h5, 2'h0, 2'h0, 1'b0, 5'd1);
      op(3'h5, 2'h0, 2'h0, 1'b0, 5'd0);
      op(3'h1, 2'h0, 2'h0, 1'b0, 5'd23);
      op(3'h3, 2'h3, 2'h0, 1'b0, 5'd0);
      op(3'h4, 2'h3, 2'h0, 1'b0, 5'd0);
      op(3'h0, 2'h0, 2'h2, 1'b0, 5'd0);
      op(3'h0, 2'h0, 2'h3, 1'b1, 5'd0);
      op(3'h1, 2'h1, 2'h0, 1'b0, 5'd7);
      op(3'h2, 2'h2, 2'h0, 1'b0, 5'd12);
      op(3'h3, 2'h0, 2'h0, 1'b0, 5'd23);
      op(3'h4, 2'h1, 2'h0, 1'b0, 5'd0);
      op(3'h6, 2'h0, 2'h0, 1'b0, 5'd0);
      for (int i = 0; i < 60; i++)
      begin
         fl = 4'($urandom);
         xfer(1'b1, CLBO_OFS_STAT, {27'h0, fl, 1'b0});
         imm = 24'($urandom);
         xfer(1'b1, CLBO_OFS_IMM, {8'h00, imm});
         xfer(1'b0, CLBO_OFS_IMM, 32'h0);
         chk(rd, 32'(imm));
         op(3'($urandom_range(6, 0)), 2'($urandom), 2'($urandom),
            1'($urandom), 5'($urandom_range(23, 0)));
      end
      test_done();
   end
endmodule
`default_nettype wire
